/* hw/sram_host.sv */
// Purpose: Host controller driving an asynchronous ECC static memory
// Assumes: Memory pins sampled synchronously to mclk_i
// Notes: One access at a time; strap is sampled after reset release
`include "sram_host_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sram_host (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  // User request side
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [`DATA_W-1:0] wdata_i,
  input wire logic [1:0] lane_i,
  output logic busy_o,
  output logic done_o,
  output logic [`DATA_W-1:0] rdata_o,
  output logic corrected_o,
  output logic wide_o,
  // Board strap sense
  input wire logic width_strap_i,
  // Memory pins
  output logic [`ADDR_W-1:0] mem_addr_o,
  output logic select_low_active_n_o,
  output logic select_high_active_o,
  output logic write_n_o,
  output logic out_en_n_o,
  output logic upper_lane_n_o,
  output logic lower_lane_n_o,
  input wire logic [`DATA_W-1:0] mem_data_i,
  output logic [`DATA_W-1:0] mem_data_o,
  output logic [`DATA_W-1:0] mem_data_oe_o,
  input wire logic err_flag_i
);
  sram_host_pkg::state_t st_reg, st_next;
  logic [`ADDR_W-1:0] addr_reg, addr_next; // Held address
  logic [`DATA_W-1:0] wd_reg, wd_next; // Write data
  logic [`DATA_W-1:0] oe_reg, oe_next; // Data drive enables
  logic [`DATA_W-1:0] rd_reg, rd_next; // Captured read data
  logic [1:0] lane_reg, lane_next; // Active-high lanes, bit1 upper
  logic sel_reg, sel_next; // Memory selected
  logic wr_reg, wr_next; // Write strobe active
  logic oen_reg, oen_next; // Output drive asked
  logic done_reg, done_next;
  logic cor_reg, cor_next;
  logic busy_reg, busy_next; // Access in progress, kept in a flop for the pin
  logic wide_reg; // Latched organisation
  logic strap_seen_reg; // Strap captured once
  logic t_load;
  logic [`CNT_W-1:0] t_val;
  logic t_done;

  // Phase pacing counter
  cycle_timer timer_u (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(clk_en_i),
    .load_i(t_load),
    .value_i(t_val),
    .done_o(t_done)
  );

  // Strap is board wiring; caught once after reset, wide organisation loaded by reset until then
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      strap_seen_reg <= 1'b0;
      wide_reg <= 1'b1;
    end else if (clk_en_i && !strap_seen_reg) begin
      strap_seen_reg <= 1'b1;
      wide_reg <= width_strap_i;
    end
  end

  // Sequence next values
  always_comb begin
    st_next = st_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    oe_next = oe_reg;
    rd_next = rd_reg;
    lane_next = lane_reg;
    sel_next = sel_reg;
    wr_next = wr_reg;
    oen_next = oen_reg;
    done_next = 1'b0;
    cor_next = cor_reg;
    t_load = 1'b0;
    t_val = '0;
    unique case (st_reg)
      sram_host_pkg::ST_IDLE: begin
        // Everything inactive: memory floats and stands by
        sel_next = 1'b0;
        wr_next = 1'b0;
        oen_next = 1'b0;
        oe_next = '0;
        lane_next = 2'b00;
        // Requests wait until the strap is known
        if (req_i && strap_seen_reg) begin
          // Address set in the same cycle select goes active
          addr_next = addr_i;
          wd_next = wdata_i;
          sel_next = 1'b1;
          // Byte mode ignores lanes but one is kept active
          lane_next = wide_reg ? lane_i : 2'b01;
          t_load = 1'b1;
          if (wr_i) begin
            // Drive stays off until the memory has released
            st_next = sram_host_pkg::ST_WR_TURN;
            t_val = `CNT_W'(`T_TURN_CYC);
          end else begin
            oen_next = 1'b1;
            st_next = sram_host_pkg::ST_RD;
            t_val = `CNT_W'(`T_READ_CYC);
          end
        end
      end
      sram_host_pkg::ST_RD: begin
        // Wait out address to data valid, then sample data and flag
        if (t_done) begin
          rd_next = '0;
          if (lane_reg[0]) begin
            rd_next[7:0] = mem_data_i[7:0];
          end
          if (lane_reg[1] && wide_reg) begin
            rd_next[15:8] = mem_data_i[15:8];
          end
          // Flag taken in the same cycle as its data
          cor_next = err_flag_i;
          done_next = 1'b1;
          sel_next = 1'b0;
          oen_next = 1'b0;
          lane_next = 2'b00;
          st_next = sram_host_pkg::ST_IDLE;
        end
      end
      sram_host_pkg::ST_WR_TURN: begin
        // Start write once the turnaround count runs out; select and lanes went active on entry
        if (t_done) begin
          wr_next = 1'b1;
          oe_next[7:0] = {8{lane_reg[0]}};
          oe_next[15:8] = {8{lane_reg[1] & wide_reg}};
          t_load = 1'b1;
          t_val = `CNT_W'(`T_WRITE_CYC);
          st_next = sram_host_pkg::ST_WR_PULSE;
        end
      end
      sram_host_pkg::ST_WR_PULSE: begin
        // Strobe ends the write first; data held past that edge
        if (t_done) begin
          wr_next = 1'b0;
          t_load = 1'b1;
          t_val = `CNT_W'(`T_HOLD_CYC);
          st_next = sram_host_pkg::ST_WR_HOLD;
        end
      end
      sram_host_pkg::ST_WR_HOLD: begin
        if (t_done) begin
          oe_next = '0;
          sel_next = 1'b0;
          lane_next = 2'b00;
          done_next = 1'b1;
          st_next = sram_host_pkg::ST_IDLE;
        end
      end
      default: begin
        st_next = sram_host_pkg::ST_IDLE;
      end
    endcase
    // Busy follows the next state so the pin needs no decode after the flop
    busy_next = (st_next != sram_host_pkg::ST_IDLE);
  end

  // Register the sequence state
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st_reg <= sram_host_pkg::ST_IDLE;
      addr_reg <= '0;
      wd_reg <= '0;
      oe_reg <= '0;
      rd_reg <= '0;
      lane_reg <= 2'b00;
      sel_reg <= 1'b0;
      wr_reg <= 1'b0;
      oen_reg <= 1'b0;
      done_reg <= 1'b0;
      cor_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else if (clk_en_i) begin
      st_reg <= st_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      oe_reg <= oe_next;
      rd_reg <= rd_next;
      lane_reg <= lane_next;
      sel_reg <= sel_next;
      wr_reg <= wr_next;
      oen_reg <= oen_next;
      done_reg <= done_next;
      cor_reg <= cor_next;
      busy_reg <= busy_next;
    end
  end

  // Pins straight from flip-flops, active-low where the memory wants it
  assign mem_addr_o = addr_reg;
  assign select_low_active_n_o = ~sel_reg;
  assign select_high_active_o = sel_reg;
  assign write_n_o = ~wr_reg;
  assign out_en_n_o = ~oen_reg;
  assign upper_lane_n_o = ~lane_reg[1];
  assign lower_lane_n_o = ~lane_reg[0];
  assign mem_data_o = wd_reg;
  assign mem_data_oe_o = oe_reg;
  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign rdata_o = rd_reg;
  assign corrected_o = cor_reg;
  assign wide_o = wide_reg;
endmodule : sram_host
`default_nettype wire

/* hw/sram_host_consts.svh */
// Purpose: Timing counts and bus widths for the static memory host
// Assumes: 100 MHz clock, 10 ns period, 45 ns speed grade
// Notes: Least times round up to whole cycles
`ifndef SRAM_HOST_CONSTS_SVH
`define SRAM_HOST_CONSTS_SVH
`define CLK_PERIOD_NS 10
// Read cycle time and address to data valid, ns
`define T_READ_NS 45
`define T_READ_CYC ((`T_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Write strobe pulse width, ns
`define T_WRITE_NS 35
`define T_WRITE_CYC ((`T_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Bus turnaround after output drive released, ns
`define T_TURN_NS 18
`define T_TURN_CYC ((`T_TURN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Data hold after the write end, cycles
`define T_HOLD_CYC 1
`define CNT_W 4
`define ADDR_W 21
`define DATA_W 16
`endif

/* hw/sram_host_pkg.sv */
// Purpose: Types for the static memory host
// Assumes: Constants header holds the numbers
// Notes: None
package sram_host_pkg;
  // Controller sequence states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD,
    ST_WR_TURN,
    ST_WR_PULSE,
    ST_WR_HOLD
  } state_t;
endpackage : sram_host_pkg

/* hw/cycle_timer.sv */
// Purpose: Loadable down counter pacing each phase of a bus cycle
// Assumes: Load and enable are synchronous
// Notes: Done is high when the count reaches zero
`include "sram_host_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cycle_timer (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [`CNT_W-1:0] value_i,
  output logic done_o
);
  logic [`CNT_W-1:0] cnt_reg; // Remaining cycles
  logic [`CNT_W-1:0] cnt_next;

  // Next count: load wins over counting
  always_comb begin
    cnt_next = cnt_reg;
    if (load_i) begin
      cnt_next = value_i;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Register the count; frozen while clock enable low
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cnt_reg <= '0;
    end else if (ce_i) begin
      cnt_reg <= cnt_next;
    end
  end

  assign done_o = (cnt_reg == '0);
endmodule : cycle_timer
`default_nettype wire

/* verification/sram_host_assertions.sv */
// Purpose: Pin protocol checks for the memory host
// Assumes: Sync active-low reset, one clock
// Notes: Watches memory pins plus busy and done
`include "sram_host_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sram_host_assertions (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [`ADDR_W-1:0] mem_addr_o,
  input wire logic select_low_active_n_o,
  input wire logic select_high_active_o,
  input wire logic write_n_o,
  input wire logic out_en_n_o,
  input wire logic upper_lane_n_o,
  input wire logic lower_lane_n_o,
  input wire logic [`DATA_W-1:0] mem_data_o,
  input wire logic [`DATA_W-1:0] mem_data_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  a_select_pair: assert property (
    select_low_active_n_o == !select_high_active_o) else $error("selects split");
  a_idle_quiet: assert property (
    !busy_o |-> select_low_active_n_o && write_n_o && out_en_n_o
    && mem_data_oe_o == '0) else $error("pins active while idle");
  a_write_qual: assert property (
    !write_n_o |-> !select_low_active_n_o && out_en_n_o
    && !(upper_lane_n_o && lower_lane_n_o)) else $error("write unqualified");
  a_lane_drive: assert property (
    !write_n_o |-> mem_data_oe_o == {{8{!upper_lane_n_o}}, {8{!lower_lane_n_o}}})
    else $error("drive lanes wrong");
  a_read_quiet: assert property (
    !out_en_n_o |-> write_n_o && mem_data_oe_o == '0)
    else $error("host drives in read");
  a_read_len: assert property (
    $fell(out_en_n_o) |-> (!out_en_n_o)[*5] ##[1:2] (out_en_n_o && done_o))
    else $error("read length wrong");
  a_strobe_width: assert property (
    $fell(write_n_o) |-> (!write_n_o)[*5] ##1 write_n_o)
    else $error("strobe width");
  a_data_hold: assert property (
    $rose(write_n_o) |-> mem_data_oe_o != '0 && $stable(mem_data_o)
    ##1 mem_data_oe_o != '0 ##1 mem_data_oe_o == '0)
    else $error("data hold wrong");
  a_addr_steady: assert property (
    !select_low_active_n_o && !$fell(select_low_active_n_o) |-> $stable(mem_addr_o))
    else $error("address moved");
endmodule : sram_host_assertions
bind sram_host sram_host_assertions u_chk (.mclk_i, .rstn_i, .busy_o, .done_o,
  .mem_addr_o, .select_low_active_n_o, .select_high_active_o, .write_n_o,
  .out_en_n_o, .upper_lane_n_o, .lower_lane_n_o, .mem_data_o, .mem_data_oe_o);
`default_nettype wire

/* verification/sram_model.sv */
// Purpose: Behavioural ECC static memory, wide or byte organisation
// Assumes: Sixteen words, address bit 4 reports a corrected read
// Notes: Released lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module sram_model (
  input wire logic mclk_i,
  input wire logic wide_i,
  input wire logic [20:0] addr_i,
  input wire logic sel_n_i,
  input wire logic sel_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic ub_n_i,
  input wire logic lb_n_i,
  input wire logic [15:0] din_i,
  output logic [15:0] dq_o,
  output logic err_o
);
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0000;
  logic act;
  logic rd;
  logic lo_en; // Low byte served
  logic hi_en; // High byte served
  initial foreach (mem[i]) mem[i] = 16'h0000;
  // Byte organisation ignores both lanes and uses lines 0 to 7 only
  assign lo_en = wide_i ? !lb_n_i : 1'b1;
  assign hi_en = wide_i && !ub_n_i;
  assign act = !sel_n_i && sel_i;
  assign rd = act && we_n_i && !oe_n_i;
  // Output lanes; floating lanes never repeat old data
  always_comb begin
    dq_o = ~last;
    if (rd && lo_en) dq_o[7:0] = mem[addr_i[3:0]][7:0];
    if (rd && hi_en) dq_o[15:8] = mem[addr_i[3:0]][15:8];
    err_o = !last[0];
    if (rd && (lo_en || hi_en)) err_o = addr_i[4];
  end
  always @(posedge mclk_i) if (rd) last <= dq_o;
  // Store at the terminating strobe edge
  always @(posedge we_n_i) begin
    if (act && lo_en) mem[addr_i[3:0]][7:0] <= din_i[7:0];
    if (act && hi_en) mem[addr_i[3:0]][15:8] <= din_i[15:8];
  end
endmodule : sram_model
`default_nettype wire

/* verification/tb_top.sv */
// Purpose: Self-checking bench for the memory host
// Assumes: Wide strap first, byte strap after a mid-run reset
// Notes: Address bit 4 asks for a corrected read
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rstn, req, wr, busy, done, corr, wide, sln, sh, wen, oen, un, ln, err;
  logic ce; // Clock enable, dropped to freeze the controller
  logic strap; // Board width strap, high for sixteen bits
  logic [1:0] lane;
  logic [20:0] addr, maddr;
  logic [15:0] wdata, rdata, mdo, moe, dq, mdi;
  logic [15:0] shadow [16];
  logic [31:0] r;
  int err_count, total_checks, seed;
  // Host drive wins per bit where enabled
  assign mdi = (moe & mdo) | (~moe & dq);
  sram_host u_dut (.mclk_i(clk), .rstn_i(rstn), .clk_en_i(ce), .req_i(req),
    .wr_i(wr), .addr_i(addr), .wdata_i(wdata), .lane_i(lane), .busy_o(busy),
    .done_o(done), .rdata_o(rdata), .corrected_o(corr), .wide_o(wide),
    .width_strap_i(strap), .mem_addr_o(maddr), .select_low_active_n_o(sln),
    .select_high_active_o(sh), .write_n_o(wen), .out_en_n_o(oen),
    .upper_lane_n_o(un), .lower_lane_n_o(ln), .mem_data_i(mdi),
    .mem_data_o(mdo), .mem_data_oe_o(moe), .err_flag_i(err));
  sram_model u_mem (.mclk_i(clk), .wide_i(strap), .addr_i(maddr),
    .sel_n_i(sln), .sel_i(sh),
    .we_n_i(wen), .oe_n_i(oen), .ub_n_i(un), .lb_n_i(ln), .din_i(mdi),
    .dq_o(dq), .err_o(err));
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", what, e, g);
      err_count++;
    end
  endtask : chk
  // Unread lanes come back as zero
  function automatic logic [15:0] exp_rd(input logic [3:0] a, input logic [1:0] l);
    return {l[1] ? shadow[a][15:8] : 8'h00, l[0] ? shadow[a][7:0] : 8'h00};
  endfunction : exp_rd
  task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d,
    input logic [1:0] l, input int hold);
    int n;
    @(negedge clk);
    req = 1'b1;
    wr = w;
    addr = {16'h0000, a};
    wdata = d;
    lane = l;
    // Byte organisation serves the low lane whatever is asked
    l = strap ? l : 2'h1;
    ce = (hold == 0);
    // Frozen cycles: the standing request must not be taken
    if (hold > 0) begin
      repeat (hold) @(negedge clk);
      chk("frozen busy", 16'h0000, {15'h0000, busy});
      ce = 1'b1;
    end
    @(negedge clk);
    req = 1'b0;
    n = 0;
    // Bounded wait for the completion pulse
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("done", 16'h0001, {15'h0000, done});
    if (w) begin
      if (l[0]) shadow[a[3:0]][7:0] = d[7:0];
      if (l[1]) shadow[a[3:0]][15:8] = d[15:8];
    end else begin
      chk("rdata", exp_rd(a[3:0], l), rdata);
      chk("corrected", {15'h0000, a[4]}, {15'h0000, corr});
    end
  endtask : access
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // About seventy accesses of under thirty cycles each; ample margin
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end
  initial begin
    {rstn, req, wr, addr, wdata, lane} = '0;
    ce = 1'b1;
    strap = 1'b1;
    seed = 81347;
    foreach (shadow[i]) shadow[i] = 16'h0000;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk("wide", 16'h0001, {15'h0000, wide});
    chk("idle pins", 16'h0003, {14'h0000, sln, oen});
    access(1'b1, 5'h03, 16'hffff, 2'h3, 0);
    access(1'b1, 5'h03, 16'h1234, 2'h1, 3);
    access(1'b1, 5'h13, 16'h5a00, 2'h2, 0);
    access(1'b0, 5'h03, 16'h0000, 2'h3, 2);
    for (int l = 1; l < 4; l++) access(1'b0, 5'h13, 16'h0000, 2'(l), 0);
    $display("test corner done");
    repeat (40) begin
      r = $random(seed);
      access(r[31], r[4:0], r[23:8],
        r[27:26] == 2'h0 ? 2'h3 : r[27:26], int'(r[29:28]));
    end
    $display("test random done");
    // Mid-run reset into byte organisation; memory contents survive
    @(negedge clk);
    rstn = 1'b0;
    strap = 1'b0;
    repeat (4) @(negedge clk);
    chk("reset wide", 16'h0001, {15'h0000, wide});
    rstn = 1'b1;
    @(negedge clk);
    chk("byte wide", 16'h0000, {15'h0000, wide});
    access(1'b1, 5'h05, 16'hbeef, 2'h2, 0);
    access(1'b0, 5'h15, 16'h0000, 2'h2, 1);
    repeat (16) begin
      r = $random(seed);
      access(r[31], r[4:0], r[23:8], r[27:26], int'(r[29:28]));
    end
    $display("test byte done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
